// file: rtl/subtract_alu_ops.sv
// subtract datapath: immediate_minus_acc and register_minus_acc over four phases
//
// Behaviour
// - immediate_minus_acc puts the 8-bit immediate minus the accumulator into the accumulator.
// - immediate_minus_acc takes one word and one cycle: decode, read immediate, compute, write accumulator.
// - register_minus_acc computes the file register minus the accumulator, reading in phase two, writing in four.
// - register_minus_acc writes the accumulator when the destination bit is zero, else the source register.
// - carry is set when no borrow occurs, so it reads as an inverted borrow.
// - a subtrahend larger than the minuend clears carry and sets negative from result bit 7.
// - a zero difference sets zero and carry and clears negative; a nonzero one clears zero.
// - negative differences are kept as 8-bit two's complement, wrapping modulo 256.
`timescale 1ns/1ps
`default_nettype none
module subtract_alu_ops (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic [15:0]            instr_word,   // sampled in decode phase
  input  wire logic                   instr_valid,
  input  wire logic [3:0]             bank_pointer,
  input  wire logic [7:0]             file_rd_data, // answer to file_rd_addr, same cycle
  output logic      [11:0]            file_rd_addr,
  output sub_alu_pkg::file_wr_t       file_wr,
  output logic      [7:0]             acc,
  output logic      [4:0]             status_flags,
  output sub_alu_pkg::phase_t         phase,
  output logic                        done
);
  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  sub_alu_pkg::phase_t phase_q;
  logic        is_imm_q, is_reg_q, dest_q;
  logic [7:0]  operand_q, diff_q;
  logic [4:0]  flags_d;
  logic [11:0] addr_q;
  logic        dec_imm, dec_reg;

  assign dec_imm = instr_valid && (instr_word[15:8] == sub_alu_pkg::IMM_PREFIX);
  assign dec_reg = instr_valid && (instr_word[15:10] == sub_alu_pkg::REG_PREFIX);

  // free running phase counter; one instruction per four phases
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      phase_q <= sub_alu_pkg::PH_DECODE;
    else
      case (phase_q)
        sub_alu_pkg::PH_DECODE:  phase_q <= sub_alu_pkg::PH_READ;
        sub_alu_pkg::PH_READ:    phase_q <= sub_alu_pkg::PH_PROCESS;
        sub_alu_pkg::PH_PROCESS: phase_q <= sub_alu_pkg::PH_WRITE;
        default:                 phase_q <= sub_alu_pkg::PH_DECODE;
      endcase
  assign phase = phase_q;

  // ---------------------------------------------------------------
  // decode (phase one)
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      is_imm_q <= 1'b0;
      is_reg_q <= 1'b0;
      dest_q   <= 1'b0;
      addr_q   <= 12'h000;
    end
    else if (phase_q == sub_alu_pkg::PH_DECODE)
    begin
      is_imm_q <= dec_imm;
      is_reg_q <= dec_reg;
      dest_q   <= instr_word[sub_alu_pkg::DEST_BIT];
      // bank select from access bit
      addr_q   <= {instr_word[sub_alu_pkg::ACCESS_BIT] ? bank_pointer : sub_alu_pkg::BANK_FIXED,
                   instr_word[7:0]};
    end

  assign file_rd_addr = addr_q;

  // ---------------------------------------------------------------
  // operand read (phase two)
  // ---------------------------------------------------------------
  logic [7:0] imm_q;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      imm_q <= 8'h00;
    else if (phase_q == sub_alu_pkg::PH_DECODE)
      imm_q <= instr_word[7:0];

  // the file answer is combinational, so it is taken on the edge that ends phase two
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      operand_q <= 8'h00;
    else if (phase_q == sub_alu_pkg::PH_READ)
      operand_q <= is_imm_q ? imm_q : file_rd_data;

  // ---------------------------------------------------------------
  // compute (phase three)
  // ---------------------------------------------------------------
  logic [8:0] wide_d;
  logic [4:0] nib_d;
  logic [7:0] res_d;
  always_comb
  begin
    wide_d = {1'b0, operand_q} + {1'b0, ~acc} + 9'h001;
    nib_d  = {1'b0, operand_q[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    res_d  = wide_d[7:0];
    flags_d = sub_alu_pkg::FLAGS_RESET;
    flags_d[sub_alu_pkg::FLAG_C]  = wide_d[8];
    flags_d[sub_alu_pkg::FLAG_DC] = nib_d[4];
    flags_d[sub_alu_pkg::FLAG_Z]  = (res_d == 8'h00);
    flags_d[sub_alu_pkg::FLAG_N]  = res_d[7];
    // signed overflow: operands of opposite sign and result sign differs from minuend
    flags_d[sub_alu_pkg::FLAG_OV] = (operand_q[7] ^ acc[7]) & (operand_q[7] ^ res_d[7]);
  end

  logic [4:0] pflags_q;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      diff_q   <= 8'h00;
      pflags_q <= sub_alu_pkg::FLAGS_RESET;
    end
    else if (phase_q == sub_alu_pkg::PH_PROCESS)
    begin
      diff_q   <= res_d;
      pflags_q <= flags_d;
    end

  // ---------------------------------------------------------------
  // write back (phase four)
  // ---------------------------------------------------------------
  logic active;
  assign active = (phase_q == sub_alu_pkg::PH_WRITE) && (is_imm_q || is_reg_q);

  // accumulator: immediate form always, register form only with dest clear
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      acc <= sub_alu_pkg::ACC_RESET;
    else if (active && (is_imm_q || !dest_q))
      acc <= diff_q;

  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      status_flags <= sub_alu_pkg::FLAGS_RESET;
    else if (active)
      status_flags <= pflags_q;

  // file write strobe is a one-cycle pulse after the write phase
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      file_wr <= '0;
    else
    begin
      file_wr.en   <= active && is_reg_q && dest_q;
      file_wr.addr <= addr_q;
      file_wr.data <= diff_q;
    end

  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      done <= 1'b0;
    else
      done <= active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_imm_issue;
    phase_q == sub_alu_pkg::PH_DECODE && dec_imm;
  endsequence

  sequence s_reg_issue;
    phase_q == sub_alu_pkg::PH_DECODE && dec_reg;
  endsequence

  a_imm_result: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_imm_issue |-> ##4 acc == 8'($past(instr_word[7:0], 4) - $past(acc, 4)))
    else $error("immediate subtract result wrong");
  a_imm_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_imm_issue |-> ##4 done)
    else $error("immediate subtract not done in one cycle");
  a_reg_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_reg_issue |-> ##4 done)
    else $error("register subtract not done in one cycle");
  a_dest_file: assert property (@(posedge sys_clk) disable iff (!rstn)
    file_wr.en |-> $stable(acc) && done)
    else $error("accumulator changed on file destination");
  a_carry_borrow: assert property (@(posedge sys_clk) disable iff (!rstn)
    phase_q == sub_alu_pkg::PH_PROCESS |-> flags_d[sub_alu_pkg::FLAG_C] == (operand_q >= acc))
    else $error("carry not inverted borrow");
  a_neg_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    phase_q == sub_alu_pkg::PH_PROCESS && operand_q < acc |-> !flags_d[sub_alu_pkg::FLAG_C]
                                                           && flags_d[sub_alu_pkg::FLAG_N] == res_d[7])
    else $error("carry set on borrow");
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    done |-> (status_flags[sub_alu_pkg::FLAG_Z] == (diff_q == 8'h00))
             && (!status_flags[sub_alu_pkg::FLAG_Z] || status_flags[sub_alu_pkg::FLAG_C])
             && (!status_flags[sub_alu_pkg::FLAG_Z] || !status_flags[sub_alu_pkg::FLAG_N]))
    else $error("zero flag inconsistent");
  a_wrap_diff: assert property (@(posedge sys_clk) disable iff (!rstn)
    phase_q == sub_alu_pkg::PH_PROCESS |=> diff_q == 8'($past(operand_q) - $past(acc)))
    else $error("difference not modulo 256");
  a_bank_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_reg_issue and !instr_word[sub_alu_pkg::ACCESS_BIT]) |=> file_rd_addr[11:8] == sub_alu_pkg::BANK_FIXED)
    else $error("fixed bank not selected");
  a_bank_ptr: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_reg_issue and instr_word[sub_alu_pkg::ACCESS_BIT]) |=> file_rd_addr[11:8] == $past(bank_pointer))
    else $error("bank pointer not used for upper address");
  a_low_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_reg_issue |=> file_rd_addr[7:0] == $past(instr_word[7:0]))
    else $error("file register address wrong");

  // one-cycle pulses and a quiet accumulator between writes; one instruction per four edges
  a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    done |=> !done)
    else $error("completion pulse longer than one cycle");
  a_file_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    file_wr.en |=> !file_wr.en)
    else $error("file write strobe longer than one cycle");
  a_acc_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    phase_q != sub_alu_pkg::PH_WRITE |=> $stable(acc))
    else $error("accumulator changed outside the write phase");
endmodule : subtract_alu_ops
`default_nettype wire

// file: common/sub_alu_pkg.sv
// package: encodings, phase states, flag layout and carriers for the subtract datapath
`default_nettype none
package sub_alu_pkg;
  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [7:0] IMM_PREFIX   = 8'h08;  // 0000 1000 kkkk kkkk
  localparam logic [5:0] REG_PREFIX   = 6'h17;  // 0101 11da ffff ffff
  localparam int         DEST_BIT     = 9;
  localparam int         ACCESS_BIT   = 8;
  localparam logic [7:0] ACC_RESET    = 8'h00;
  localparam logic [3:0] BANK_FIXED   = 4'h0;   // fixed access bank
  // flag positions in the status byte
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  // register file write request
  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } file_wr_t;
endpackage : sub_alu_pkg
`default_nettype wire

// file: tb/subtract_alu_ops_tb_top.sv
// self-checking bench for the subtract datapath
`timescale 1ns/1ps
`default_nettype none
module subtract_alu_ops_tb_top;
  logic                  sys_clk      = 1'b0;
  logic                  rstn         = 1'b0;
  logic [15:0]           instr_word   = 16'h0000;
  logic                  instr_valid  = 1'b0;
  logic [3:0]            bank_pointer = 4'hA;
  logic [7:0]            file_rd_data = 8'h00;
  logic [11:0]           file_rd_addr;
  sub_alu_pkg::file_wr_t file_wr;
  logic [7:0]            acc;
  logic [4:0]            status_flags;
  sub_alu_pkg::phase_t   phase;
  logic                  done;
  int                    fail_count   = 0;
  int                    cmp_count    = 0;
  int                    cycles       = 0;
  logic [7:0]            acc_m        = 8'h00;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  subtract_alu_ops dut (.sys_clk(sys_clk), .rstn(rstn), .instr_word(instr_word), .instr_valid(instr_valid),
    .bank_pointer(bank_pointer), .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr), .file_wr(file_wr),
    .acc(acc), .status_flags(status_flags), .phase(phase), .done(done));

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // one instruction; minuend m comes from the immediate or the file read answer
  task automatic do_op(input logic [15:0] iw, input logic [7:0] m, input logic [11:0] addr);
    logic [7:0] r;
    logic [4:0] f;
    logic       reg_form;
    logic       to_file;
    int         n;
    r = m - acc_m;
    f = 5'h00;
    f[sub_alu_pkg::FLAG_C]  = (m >= acc_m);
    f[sub_alu_pkg::FLAG_DC] = (m[3:0] >= acc_m[3:0]);
    f[sub_alu_pkg::FLAG_Z]  = (r == 8'h00);
    f[sub_alu_pkg::FLAG_OV] = (m[7] != acc_m[7]) && (r[7] != m[7]);
    f[sub_alu_pkg::FLAG_N]  = r[7];
    reg_form = (iw[15:10] == sub_alu_pkg::REG_PREFIX);
    to_file = reg_form && iw[sub_alu_pkg::DEST_BIT];
    n = 0;
    while (phase !== sub_alu_pkg::PH_DECODE && n < 8)
    begin
      @(negedge sys_clk);
      n++;
    end
    instr_word = iw;
    instr_valid = 1'b1;
    file_rd_data = m;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    if (reg_form) chk(file_rd_addr === addr, "read address");
    n = 0;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n == 3, "completion timing");
    chk(acc === (to_file ? acc_m : r), "accumulator value");
    chk(status_flags === f, "status flags");
    chk(file_wr.en === to_file, "write strobe");
    if (to_file) chk(file_wr.addr === addr && file_wr.data === r, "write back");
    if (!to_file) acc_m = r;
  endtask : do_op

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_imm_cases;
    do_op(16'h0801, 8'h01, 12'h000);
    do_op(16'h0802, 8'h02, 12'h000);
    do_op(16'h0803, 8'h03, 12'h000);
    do_op(16'h0802, 8'h02, 12'h000);
    do_op(16'h0803, 8'h03, 12'h000);
    do_op(16'h0802, 8'h02, 12'h000);
  endtask : t_imm_cases

  // boundary immediates back to back, stirring overflow and nibble borrow
  task automatic t_imm_bounds;
    logic [7:0] ks [5] = '{8'h00, 8'h80, 8'hFF, 8'h10, 8'h0F};
    foreach (ks[i]) do_op({sub_alu_pkg::IMM_PREFIX, ks[i]}, ks[i], 12'h000);
  endtask : t_imm_bounds

  // every destination and access combination of the register form
  task automatic t_reg_forms;
    logic [7:0] fa;
    for (int i = 0; i < 4; i++)
    begin
      fa = 8'h3C + 8'(i * 37);
      do_op({sub_alu_pkg::REG_PREFIX, i[1], i[0], fa}, 8'h91 - 8'(i * 50),
            {(i[0] ? bank_pointer : sub_alu_pkg::BANK_FIXED), fa});
    end
  endtask : t_reg_forms

  // foreign opcode and an unqualified word must leave everything alone
  task automatic t_refused;
    for (int i = 0; i < 2; i++)
    begin
      while (phase !== sub_alu_pkg::PH_DECODE) @(negedge sys_clk);
      instr_word = i ? 16'h08AA : 16'h0A55;
      instr_valid = !i[0];
      repeat (8)
      begin
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(done === 1'b0 && file_wr.en === 1'b0, "ignored word acted");
      end
      chk(acc === acc_m, "accumulator disturbed");
    end
  endtask : t_refused

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // hang guard, well beyond the roughly 80 cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      $display("[FAIL] %0t run timed out", $time);
      summarize();
    end
  end

  initial
  begin
    repeat (5) @(negedge sys_clk);
    chk(acc === sub_alu_pkg::ACC_RESET && status_flags === sub_alu_pkg::FLAGS_RESET, "reset values");
    chk(phase === sub_alu_pkg::PH_DECODE && done === 1'b0 && file_wr.en === 1'b0, "reset outputs");
    rstn = 1'b1;
    t_imm_cases();
    t_imm_bounds();
    t_reg_forms();
    t_refused();
    summarize();
  end
endmodule : subtract_alu_ops_tb_top
`default_nettype wire
